// ===== rst_seq_pkg.sv
// Constants shared by the warm-reset sequencer ends
// How it works
// - Falling reset restores registers, recovery in 35 us
// - Failed power-on makes reset run full power-up
// - Reset stays high 50 ns before next pulse
// - Reset low 200 ns; device aborts, floats, ignores
// - Select waits 35 us after reset falls
// - Select raised in recovery, lowered 50 ns later
// - Pulse plus hold cover the recovery period
// - Reset ignored during power-up; held reset persists
// - Basic reads clocked at 50 MHz at most
// - Other single-bit commands at 133 MHz at most
// - Quad page write at 80 MHz at most
// - No selection until power-up interval elapses
package rst_seq_pkg;
    localparam int CLK_MHZ                = 50;
    localparam int CLK_NS                 = 1000 / CLK_MHZ;
    localparam int RESTART_SETUP_NS       = 50;
    localparam int RESTART_PULSE_NS       = 200;
    localparam int RESTART_HOLD_NS        = 50;
    localparam int RESTART_RECOVERY_US    = 35;
    localparam int POWER_UP_US            = 300;
    // Least times round up to whole cycles
    localparam int SETUP_CYC    = (RESTART_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC    = (RESTART_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC     = (RESTART_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVERY_CYC = RESTART_RECOVERY_US * CLK_MHZ;
    localparam int POWER_UP_CYC = POWER_UP_US * CLK_MHZ;
    localparam int CNT_W        = 24;
    // Serial clock ceilings per command class, MHz
    localparam int SCK_BASIC_MHZ  = 50;
    localparam int SCK_SINGLE_MHZ = 133;
    localparam int SCK_MULTI_MHZ  = 104;
    localparam int SCK_QPW_MHZ    = 80;
    typedef enum logic [1:0] {CLS_BASIC, CLS_SINGLE, CLS_MULTI, CLS_QPW} cmd_class_t;
endpackage

// ===== rst_link_if.sv
// Interface joining the controller and the flash reset logic
`timescale 1ns/1ps
interface rst_link_if;
    logic reset_n;
    logic sel_n;
    logic sck;
    logic sio_out;
    logic sio_oe;
    modport ctrl  (output reset_n, output sel_n, output sck, input sio_out, input sio_oe);
    modport flash (input reset_n, input sel_n, input sck, output sio_out, output sio_oe);
endinterface

// ===== flash_reset_core.sv
// Flash side: power-up, warm reset recovery and select gating
`timescale 1ns/1ps
module flash_reset_core
    import rst_seq_pkg::*;
#(
    parameter int POWER_UP_CYCLES = rst_seq_pkg::POWER_UP_CYC,
    parameter int RECOVERY_CYCLES = rst_seq_pkg::RECOVERY_CYC
)(
    input  wire logic   clk_in,
    input  wire logic   rst_in,
    rst_link_if.flash   link,
    input  wire logic   por_ok_in,
    input  wire logic   data_in,
    output logic        ready_out,
    output logic        full_por_out,
    output logic        cmd_start_out,
    output logic        abort_out
);
    import rst_seq_pkg::*;
    typedef enum logic [2:0] {ST_PWRUP, ST_HELD, ST_RECOVER, ST_WAIT_DESEL, ST_READY} fstate_t;
    fstate_t state_r;
    fstate_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [2:0] rst_sync_r;
    logic [2:0] sel_sync_r;
    logic       por_good_r;
    logic       full_r;
    logic       ready_r;
    logic       start_r;
    logic       abort_r;
    wire rst_lvl   = rst_sync_r[1];
    wire rst_fall  = rst_sync_r[2] & ~rst_sync_r[1];
    wire sel_lvl   = sel_sync_r[1];
    wire sel_fall  = sel_sync_r[2] & ~sel_sync_r[1];
    wire cnt_done  = (cnt_r == '0);
    wire [CNT_W-1:0] por_load = CNT_W'(POWER_UP_CYCLES - 1);
    wire [CNT_W-1:0] rec_load = CNT_W'(RECOVERY_CYCLES - 1);
    always_ff @(posedge clk_in)
    begin
        rst_sync_r <= {rst_sync_r[1:0], link.reset_n};
        sel_sync_r <= {sel_sync_r[1:0], link.sel_n};
    end
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_PWRUP:      if (cnt_done) state_nxt = rst_lvl ? ST_WAIT_DESEL : ST_HELD;
            ST_HELD:       if (rst_lvl) state_nxt = ST_WAIT_DESEL;
            ST_RECOVER:    if (cnt_done) state_nxt = rst_lvl ? ST_WAIT_DESEL : ST_HELD;
            ST_WAIT_DESEL: if (sel_lvl) state_nxt = ST_READY;
            ST_READY:      if (rst_fall) state_nxt = por_good_r ? ST_RECOVER : ST_PWRUP;
        endcase
    end
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state_r    <= ST_PWRUP;
            // Power-up interval counted from reset release
            cnt_r      <= por_load;
            por_good_r <= 1'b0;
            full_r     <= 1'b1;
            ready_r    <= 1'b0;
            start_r    <= 1'b0;
            abort_r    <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_r == ST_READY && rst_fall)
                cnt_r <= por_good_r ? rec_load : por_load;
            else if (!cnt_done)
                cnt_r <= cnt_r - 1'b1;
            if (state_r == ST_PWRUP && cnt_done)
                por_good_r <= por_ok_in;
            full_r  <= (state_nxt == ST_PWRUP);
            ready_r <= (state_nxt == ST_READY);
            // Commands only after a clean new select edge
            start_r <= (state_r == ST_READY) && sel_fall && !rst_fall;
            abort_r <= (state_r == ST_READY) && rst_fall;
        end
    end
    // Outputs float whenever not ready
    assign link.sio_out = ready_r & data_in;
    assign link.sio_oe  = ready_r;
    assign ready_out     = ready_r;
    assign full_por_out  = full_r;
    assign cmd_start_out = start_r;
    assign abort_out     = abort_r;
endmodule

// ===== ctrl_reset_seq.sv
// Controller side: reset pulse, select gating and clock divider
`timescale 1ns/1ps
module ctrl_reset_seq
    import rst_seq_pkg::*;
#(
    parameter int POWER_UP_CYCLES = rst_seq_pkg::POWER_UP_CYC,
    parameter int RECOVERY_CYCLES = rst_seq_pkg::RECOVERY_CYC,
    parameter int SCK_DIV         = 1
)(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    rst_link_if.ctrl         link,
    input  wire logic        hw_reset_req_in,
    input  wire logic        sel_req_in,
    input  wire cmd_class_t  cmd_class_in,
    output logic             sel_ok_out,
    output logic             busy_out
);
    import rst_seq_pkg::*;
    typedef enum logic [2:0] {C_PWRUP, C_SETUP, C_IDLE, C_PULSE, C_HOLD} cstate_t;
    cstate_t state_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic reset_n_r;
    logic sel_n_r;
    logic sck_r;
    logic ok_r;
    logic [7:0] div_r;
    // Divider covers all classes; 12.5 MHz is below every ceiling
    wire [7:0] div_lim = 8'(SCK_DIV);
    wire tick = (div_r == div_lim);
    wire cnt_done = (cnt_r == '0);
    // Pulse length chosen so the pulse alone covers recovery
    wire [CNT_W-1:0] pulse_load = CNT_W'(
        (RECOVERY_CYCLES > PULSE_CYC ? RECOVERY_CYCLES : PULSE_CYC) - 1);
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state_r   <= C_PWRUP;
            cnt_r     <= CNT_W'(POWER_UP_CYCLES - 1);
            reset_n_r <= 1'b1;
            sel_n_r   <= 1'b1;
            sck_r     <= 1'b0;
            ok_r      <= 1'b0;
            div_r     <= 8'h00;
        end
        else
        begin
            cnt_r <= cnt_done ? cnt_r : cnt_r - 1'b1;
            div_r <= tick ? 8'h00 : div_r + 8'h01;
            unique case (state_r)
                C_PWRUP: if (cnt_done)
                begin
                    state_r <= C_SETUP;
                    cnt_r   <= CNT_W'(SETUP_CYC - 1);
                end
                C_SETUP: if (cnt_done) state_r <= C_IDLE;
                C_IDLE:
                    if (hw_reset_req_in)
                    begin
                        state_r   <= C_PULSE;
                        reset_n_r <= 1'b0;
                        sel_n_r   <= 1'b1;
                        cnt_r     <= pulse_load;
                    end
                C_PULSE: if (cnt_done)
                begin
                    state_r   <= C_HOLD;
                    reset_n_r <= 1'b1;
                    cnt_r     <= CNT_W'(HOLD_CYC - 1);
                end
                C_HOLD: if (cnt_done)
                begin
                    state_r <= C_SETUP;
                    cnt_r   <= CNT_W'(SETUP_CYC - 1);
                end
            endcase
            ok_r <= (state_r == C_IDLE) && !hw_reset_req_in;
            if (state_r == C_IDLE && !hw_reset_req_in)
                sel_n_r <= ~sel_req_in;
            else
                sel_n_r <= 1'b1;
            sck_r <= (!sel_n_r && tick) ? ~sck_r : (sel_n_r ? 1'b0 : sck_r);
        end
    end
    assign link.reset_n = reset_n_r;
    assign link.sel_n   = sel_n_r;
    assign link.sck     = sck_r;
    assign sel_ok_out   = ok_r;
    assign busy_out     = ~ok_r;
endmodule

// ===== serial_flash_hw_reset_timing_chk.sv
// Checker on the reset link signals
`timescale 1ns/1ps
module serial_flash_hw_reset_timing_chk
    import rst_seq_pkg::*;
#(
    parameter int POWER_UP_CYCLES = 50,
    parameter int RECOVERY_CYCLES = 20
)(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic reset_n,
    input wire logic sel_n,
    input wire logic sck,
    input wire logic sio_out,
    input wire logic sio_oe
);
    // ****
    // Counters
    // ****
    logic [15:0] up_r;
    logic [15:0] low_r;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Low count freezes after release so select timing can be judged later
    always_ff @(posedge clk_in)
    begin
        up_r <= rst_in ? 16'h0 : up_r + {15'h0, up_r != 16'hffff};
        low_r <= rst_in ? 16'hffff : $fell(reset_n) ? 16'h1 : low_r + {15'h0, !reset_n};
    end
    property p_pls; $rose(reset_n) |-> low_r >= PULSE_CYC; endproperty
    a_pls: assert property (p_pls) else $error("pulse short");
    property p_rec; $rose(reset_n) |-> low_r >= RECOVERY_CYCLES; endproperty
    a_rec: assert property (p_rec) else $error("recovery short");
    property p_selw; $fell(sel_n) |-> low_r >= RECOVERY_CYCLES; endproperty
    a_selw: assert property (p_selw) else $error("select early");
    property p_hold; $rose(reset_n) |-> (reset_n && sel_n) [*3]; endproperty
    a_hold: assert property (p_hold) else $error("hold short");
    property p_desel; !reset_n |-> sel_n; endproperty
    a_desel: assert property (p_desel) else $error("select in reset");
    property p_pwr; up_r < POWER_UP_CYCLES |-> sel_n && reset_n; endproperty
    a_pwr: assert property (p_pwr) else $error("early access");
    property p_sck; $changed(sck) |=> $stable(sck); endproperty
    a_sck: assert property (p_sck) else $error("clock fast");
    // Flash sees the pin through two flops, so it floats three edges late
    property p_flt; $fell(reset_n) |-> ##3 !sio_oe [*8]; endproperty
    a_flt: assert property (p_flt) else $error("driven in reset");
    c_rst: cover property ($rose(reset_n));
    c_sel: cover property ($fell(sel_n));
    c_sck: cover property ($rose(sck));
endmodule

// ===== serial_flash_hw_reset_timing_tb.sv
// Testbench joining controller and flash over the reset link
`timescale 1ns/1ps
module serial_flash_hw_reset_timing_tb;
    import rst_seq_pkg::*;
    localparam int PU = 50;
    localparam int RC = 20;
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       req = 1'b0;
    logic       sel_req = 1'b0;
    logic       por_ok = 1'b1;
    logic       data = 1'b0;
    cmd_class_t cls = CLS_BASIC;
    logic       sel_ok;
    logic       busy;
    logic       ready;
    logic       full_por;
    logic       start;
    logic       abort;
    int         seed = 32'heb18;
    int         n_fail = 0;
    int         comparisons = 0;
    int         len;
    rst_link_if link ();
    ctrl_reset_seq #(.POWER_UP_CYCLES(PU), .RECOVERY_CYCLES(RC)) i_ctrl_reset_seq (
        .clk_in(clk_in), .rst_in(rst_in), .link(link.ctrl), .hw_reset_req_in(req),
        .sel_req_in(sel_req), .cmd_class_in(cls), .sel_ok_out(sel_ok), .busy_out(busy));
    flash_reset_core #(.POWER_UP_CYCLES(PU), .RECOVERY_CYCLES(RC)) i_flash_reset_core (
        .clk_in(clk_in), .rst_in(rst_in), .link(link.flash), .por_ok_in(por_ok),
        .data_in(data), .ready_out(ready), .full_por_out(full_por),
        .cmd_start_out(start), .abort_out(abort));
    serial_flash_hw_reset_timing_chk #(.POWER_UP_CYCLES(PU), .RECOVERY_CYCLES(RC))
        i_serial_flash_hw_reset_timing_chk (.clk_in(clk_in), .rst_in(rst_in),
        .reset_n(link.reset_n), .sel_n(link.sel_n), .sck(link.sck),
        .sio_out(link.sio_out), .sio_oe(link.sio_oe));
    always #10 clk_in = ~clk_in;
    // ****
    // Checks
    // ****
    task automatic chk(input logic got, input logic exp, input string msg);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    // Bounded wait, so a dead handshake shows as a mismatch, not a hang
    task automatic wait_hi(ref logic sig, input int lim, input string msg);
        for (int k = 0; k < lim && sig !== 1'b1; k++)
            @(negedge clk_in);
        chk(sig, 1'b1, msg);
    endtask
    task automatic complete_run;
        $display("Compared %0d, failed %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        n_fail++;
        complete_run();
    end
    initial
    begin
        for (int run = 0; run < 2; run++)
        begin
            @(negedge clk_in);
            por_ok = (run == 0);
            rst_in = 1'b1;
            repeat (2) @(negedge clk_in);
            rst_in = 1'b0;
            wait_hi(sel_ok, PU + 20, "no select after power-up");
            chk(ready, 1'b1, "not ready");
            chk(busy, 1'b0, "busy while select allowed");
            cls = cmd_class_t'($random(seed));
            data = $random(seed);
            sel_req = 1'b1;
            wait_hi(start, 20, "no opcode start");
            req = 1'b1;
            for (int k = 0; k < 10 && link.reset_n !== 1'b0; k++)
                @(negedge clk_in);
            req = 1'b0;
            chk(link.sel_n, 1'b1, "selected in reset");
            chk(busy, 1'b1, "not busy in reset");
            sel_req = 1'b0;
            wait_hi(abort, 8, "no abort");
            chk(link.sio_oe, 1'b0, "output driven in reset");
            for (len = 0; link.reset_n === 1'b0 && len < RC + 10; len++)
                @(negedge clk_in);
            chk(len >= RC - 6, 1'b1, "reset low short");
            chk(full_por, run == 1, "wrong reset kind");
            wait_hi(ready, PU + 30, "not back in standby");
            chk(link.sio_oe, 1'b1, "output not enabled when ready");
            chk(link.sio_out, data, "output data wrong");
            sel_req = 1'b1;
            wait_hi(start, PU + 30, "no fresh opcode");
            sel_req = 1'b0;
            $display("Run %0d done", run);
        end
        complete_run();
    end
endmodule
